/* File: common/umc_defines.vh */
`ifndef UMC_DEFINES_VH
`define UMC_DEFINES_VH

// Register byte addresses
`define UMC_ADDR_MLC      8'h00
`define UMC_ADDR_TRIG     8'h04
`define UMC_ADDR_STAT     8'h08
`define UMC_ADDR_IRQ_ST   8'h0c
`define UMC_ADDR_IRQ_EN   8'h10
`define UMC_ADDR_IRQ_CLR  8'h14

// Modem line control fields
`define UMC_HALF_BIT      7
`define UMC_TXIND_BIT     6
`define UMC_AUTO_BIT      5
`define UMC_LOOP_BIT      4
`define UMC_IRQGATE_BIT   3
`define UMC_OUT1_BIT      2
`define UMC_RTS_BIT       1
`define UMC_DTR_BIT       0
`define UMC_MLC_RESET     8'h00

// Receive trigger level field and depths
`define UMC_TRIG_RESET    2'h0
`define UMC_TRIG_LVL0     4'h1
`define UMC_TRIG_LVL1     4'h2
`define UMC_TRIG_LVL2     4'h4
`define UMC_TRIG_LVL3     4'h7

// Event status bits
`define UMC_EV_CTS        0
`define UMC_EV_DSR        1
`define UMC_EV_RI         2
`define UMC_EV_DCD        3
`define UMC_EV_RXTRIG     4
`define UMC_EV_WIDTH      5

`endif

/* File: verilog/umc_modem_control.v */
// Operation
// - Half-duplex: transmit first, receive only when idle
// - Transmit-indication bit puts tx activity on DTR
// - Auto handshake: start character only when CTS low
// - Auto handshake: CTS change raises no status event
// - Auto handshake with RTS bit: RTS low when empty
// - Deassert RTS at trigger, reassert when empty
// - Loopback: outputs inactive, signals fed back internally
// - Interrupt gate bit passes or blocks interrupt output
// - First user bit stored, feeds RI in loopback
// - RTS bit set drives RTS low, reset clear
// - DTR bit set drives DTR low, reset clear
// - Modem features except the interrupt gate bit only on primary port instance
// - Trigger code: 1, 2, 4 or 7 bytes
`timescale 1ns/1ps
`include "umc_defines.vh"

module umc_modem_control #(
	parameter PRIMARY_PORT = 1
) (
	input  wire        mclk_i,
	input  wire        rst_i,
	input  wire        hsel_i,
	input  wire [7:0]  haddr_i,
	input  wire [1:0]  htrans_i,
	input  wire        hwrite_i,
	input  wire [2:0]  hsize_i,
	input  wire [31:0] hwdata_i,
	input  wire        hready_i,
	output reg  [31:0] hrdata_o,
	output reg         hreadyout_o,
	output reg         hresp_o,
	input  wire        cts_n_i,
	input  wire        dsr_n_i,
	input  wire        ri_n_i,
	input  wire        dcd_n_i,
	input  wire        rxd_i,
	output reg         rts_n_o,
	output reg         dtr_n_o,
	output reg         txd_o,
	input  wire        core_txd_i,
	input  wire        core_tx_busy_i,
	input  wire        core_tx_pending_i,
	input  wire [3:0]  rx_fifo_count_i,
	input  wire        core_irq_i,
	output reg         core_rxd_o,
	output reg         core_rx_enable_o,
	output reg         tx_start_allow_o,
	output reg         modem_chg_o,
	output reg         irq_o
);

	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------
	function [3:0] umc_trig_depth;
		input [1:0] code;
		begin
			case (code)
				2'h0: umc_trig_depth = `UMC_TRIG_LVL0;
				2'h1: umc_trig_depth = `UMC_TRIG_LVL1;
				2'h2: umc_trig_depth = `UMC_TRIG_LVL2;
				default: umc_trig_depth = `UMC_TRIG_LVL3;
			endcase
		end
	endfunction

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	reg  [4:0] pin_s1_q;
	reg  [4:0] pin_s2_q;

	always @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			pin_s1_q <= 5'h1f;
			pin_s2_q <= 5'h1f;
		end
		else
		begin
			pin_s1_q <= {rxd_i, dcd_n_i, ri_n_i, dsr_n_i, cts_n_i};
			pin_s2_q <= pin_s1_q;
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	reg  [7:0]            mlc_q;
	reg  [1:0]            trig_q;
	reg  [`UMC_EV_WIDTH-1:0] irq_st_q;
	reg  [`UMC_EV_WIDTH-1:0] irq_en_q;
	reg                   rts_hold_q;
	reg  [3:0]            modem_prev_q;
	reg                   rx_trig_prev_q;

	reg                   dp_write_q;
	reg                   dp_read_q;
	reg  [7:0]            dp_addr_q;

	wire       prim       = (PRIMARY_PORT != 0);
	wire       half_en    = prim & mlc_q[`UMC_HALF_BIT];
	wire       txind_en   = prim & mlc_q[`UMC_TXIND_BIT];
	wire       auto_en    = prim & mlc_q[`UMC_AUTO_BIT];
	wire       loop_en    = prim & mlc_q[`UMC_LOOP_BIT];
	wire       out1_bit   = prim & mlc_q[`UMC_OUT1_BIT];
	wire       rts_bit    = prim & mlc_q[`UMC_RTS_BIT];
	wire       dtr_bit    = prim & mlc_q[`UMC_DTR_BIT];
	wire       out2_bit   = mlc_q[`UMC_IRQGATE_BIT];

	// ---------------------------------------------------------------
	// Flow control and line levels (active low)
	// ---------------------------------------------------------------
	wire       rx_empty   = (rx_fifo_count_i == 4'h0);
	wire       rx_at_trig = (rx_fifo_count_i >= umc_trig_depth(trig_q));
	wire       tx_act     = core_tx_busy_i | core_tx_pending_i;

	// Auto RTS: low when empty, released at trigger until empty again
	wire       rts_act    = auto_en ? (rts_bit & ~rts_hold_q)
	                                : rts_bit;
	wire       dtr_act    = txind_en ? tx_act : dtr_bit;

	// Loopback sources, all active low as seen by the modem inputs
	wire       cts_n_int  = loop_en ? ~rts_act   : pin_s2_q[0];
	wire       dsr_n_int  = loop_en ? ~dtr_act   : pin_s2_q[1];
	wire       ri_n_int   = loop_en ? ~out1_bit  : pin_s2_q[2];
	wire       dcd_n_int  = loop_en ? ~out2_bit  : pin_s2_q[3];
	wire       rxd_int    = loop_en ? core_txd_i : pin_s2_q[4];

	wire [3:0] modem_now  = {dcd_n_int, ri_n_int, dsr_n_int, cts_n_int};
	wire [3:0] modem_diff = modem_now ^ modem_prev_q;

	wire [`UMC_EV_WIDTH-1:0] ev_set;
	assign ev_set[`UMC_EV_CTS]    = modem_diff[0] & ~auto_en;
	assign ev_set[`UMC_EV_DSR]    = modem_diff[1];
	assign ev_set[`UMC_EV_RI]     = modem_diff[2];
	assign ev_set[`UMC_EV_DCD]    = modem_diff[3];
	assign ev_set[`UMC_EV_RXTRIG] = rx_at_trig & ~rx_trig_prev_q;

	always @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			rts_hold_q     <= 1'b0;
			modem_prev_q   <= 4'hf;
			rx_trig_prev_q <= 1'b0;
		end
		else
		begin
			if (!auto_en || rx_empty)
				rts_hold_q <= 1'b0;
			else if (rx_at_trig)
				rts_hold_q <= 1'b1;
			modem_prev_q   <= modem_now;
			rx_trig_prev_q <= rx_at_trig;
		end
	end

	// ---------------------------------------------------------------
	// AHB-Lite slave
	// ---------------------------------------------------------------
	wire       ap_valid = hsel_i & htrans_i[1] & hready_i;
	wire       wr_mlc   = dp_write_q & (dp_addr_q == `UMC_ADDR_MLC);
	wire       wr_trig  = dp_write_q & (dp_addr_q == `UMC_ADDR_TRIG);
	wire       wr_en    = dp_write_q & (dp_addr_q == `UMC_ADDR_IRQ_EN);
	wire       wr_clr   = dp_write_q & (dp_addr_q == `UMC_ADDR_IRQ_CLR);
	wire [`UMC_EV_WIDTH-1:0] clr_mask =
		wr_clr ? hwdata_i[`UMC_EV_WIDTH-1:0] : {`UMC_EV_WIDTH{1'b0}};

	reg  [31:0] rd_d;

	always @*
	begin
		rd_d = 32'h0;
		if (haddr_i == `UMC_ADDR_MLC)
			rd_d = {24'h0, mlc_q};
		else if (haddr_i == `UMC_ADDR_TRIG)
			rd_d = {30'h0, trig_q};
		else if (haddr_i == `UMC_ADDR_STAT)
			rd_d = {24'h0, rts_act, dtr_act, tx_act, rx_at_trig, ~modem_now};
		else if (haddr_i == `UMC_ADDR_IRQ_ST)
			rd_d = {27'h0, irq_st_q};
		else if (haddr_i == `UMC_ADDR_IRQ_EN)
			rd_d = {27'h0, irq_en_q};
	end

	always @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			dp_write_q  <= 1'b0;
			dp_read_q   <= 1'b0;
			dp_addr_q   <= 8'h00;
			hrdata_o    <= 32'h0;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
			mlc_q       <= `UMC_MLC_RESET;
			trig_q      <= `UMC_TRIG_RESET;
			irq_en_q    <= {`UMC_EV_WIDTH{1'b0}};
			irq_st_q    <= {`UMC_EV_WIDTH{1'b0}};
		end
		else
		begin
			dp_write_q <= ap_valid & hwrite_i;
			dp_read_q  <= ap_valid & ~hwrite_i;
			dp_addr_q  <= haddr_i;
			if (ap_valid & ~hwrite_i)
				hrdata_o <= rd_d;
			if (wr_mlc)
				mlc_q <= hwdata_i[7:0];
			if (wr_trig)
				trig_q <= hwdata_i[1:0];
			if (wr_en)
				irq_en_q <= hwdata_i[`UMC_EV_WIDTH-1:0];
			// Set wins over a clear in the same cycle
			irq_st_q <= (irq_st_q & ~clr_mask) | ev_set;
		end
	end

	// ---------------------------------------------------------------
	// Registered outputs
	// ---------------------------------------------------------------
	always @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			rts_n_o          <= 1'b1;
			dtr_n_o          <= 1'b1;
			txd_o            <= 1'b1;
			core_rxd_o       <= 1'b1;
			core_rx_enable_o <= 1'b1;
			tx_start_allow_o <= 1'b1;
			modem_chg_o      <= 1'b0;
			irq_o            <= 1'b0;
		end
		else
		begin
			// Loopback parks every external output at its idle level
			rts_n_o          <= loop_en ? 1'b1 : ~rts_act;
			dtr_n_o          <= loop_en ? 1'b1 : ~dtr_act;
			txd_o            <= loop_en ? 1'b1 : core_txd_i;
			core_rxd_o       <= (half_en & tx_act) ? 1'b1 : rxd_int;
			core_rx_enable_o <= ~(half_en & tx_act);
			tx_start_allow_o <= ~auto_en | ~cts_n_int;
			modem_chg_o      <= |ev_set[`UMC_EV_DCD:`UMC_EV_CTS];
			irq_o            <= out2_bit &
			                    (core_irq_i | |(irq_st_q & irq_en_q));
		end
	end

endmodule // umc_modem_control

/* File: testbench/umc_modem_control_assertions.sv */
`timescale 1ns/1ps
`include "umc_defines.vh"
module umc_chk (
	input wire        mclk_i, rst_i, hsel_i, hwrite_i, hready_i,
	input wire [7:0]  haddr_i,
	input wire [1:0]  htrans_i,
	input wire [31:0] hwdata_i,
	input wire [3:0]  rx_fifo_count_i,
	input wire        cts_n_i, dsr_n_i, ri_n_i, dcd_n_i, core_irq_i,
	input wire        rts_n_o, dtr_n_o, txd_o, tx_start_allow_o, modem_chg_o, irq_o
);
	// ----
	// Control mirror
	// ----
	reg        wr_q;
	reg  [7:0] a_q, m_q;
	reg  [1:0] t_q;
	wire [3:0] lvl = t_q == 2'h3 ? 4'h7 : 4'h1 << t_q;
	wire       au = m_q[5] & ~m_q[4];
	always @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			wr_q <= 1'h0;
			m_q  <= 8'h0;
			t_q  <= 2'h0;
		end
		else if (hready_i)
		begin
			wr_q <= hsel_i & htrans_i[1] & hwrite_i;
			a_q  <= haddr_i;
			if (wr_q && a_q == `UMC_ADDR_MLC) m_q <= hwdata_i[7:0];
			if (wr_q && a_q == `UMC_ADDR_TRIG) t_q <= hwdata_i[1:0];
		end
	end
	// ----
	// Properties
	// ----
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	AST_GATE_OFF: assert property (!$past(m_q[3]) |-> !irq_o)
		else $error("irq leak");
	AST_GATE_ON: assert property ($past(m_q[3]) && $past(core_irq_i) |-> irq_o)
		else $error("irq lost");
	AST_RTS: assert property (!$past(m_q[4]) && !$past(m_q[5]) |-> rts_n_o == !$past(m_q[1]))
		else $error("rts");
	AST_DTR: assert property ($past(m_q[6:4]) == 3'h0 |-> dtr_n_o == !$past(m_q[0]))
		else $error("dtr");
	AST_LOOP: assert property ($past(m_q[4]) |-> rts_n_o && dtr_n_o && txd_o)
		else $error("loop pins");
	AST_EMPTY: assert property ((au && m_q[1] && rx_fifo_count_i == 4'h0) [*3] |-> !rts_n_o)
		else $error("rts empty");
	AST_FULL: assert property ((au && rx_fifo_count_i >= lvl) [*3] |-> rts_n_o)
		else $error("rts full");
	AST_CTS: assert property ((au && cts_n_i) [*5] |-> !tx_start_allow_o)
		else $error("cts");
	AST_NOCHG: assert property ((au && $stable({dsr_n_i, ri_n_i, dcd_n_i})) [*6] |-> !modem_chg_o)
		else $error("chg");
	CVR_LOOP: cover property (m_q[4] && !txd_o);
	CVR_FULL: cover property (au && rts_n_o);
	CVR_IRQ: cover property (irq_o);
endmodule // umc_chk
bind umc_modem_control umc_chk u_chk (.*);

/* File: testbench/umc_remote_model.sv */
`timescale 1ns/1ps
module umc_remote_model (
	input  wire       txd_o,
	input  wire [3:0] lvl_i,
	output wire       rxd_i,
	output wire       cts_n_i,
	output wire [2:0] pins_o
);
	// Remote RTS drives our CTS; a cable echo returns TXD
	assign cts_n_i = lvl_i[0];
	assign pins_o  = lvl_i[3:1];
	assign rxd_i   = txd_o;
endmodule // umc_remote_model

/* File: testbench/umc_modem_control_bench.sv */
`timescale 1ns/1ps
`include "umc_defines.vh"
module umc_modem_control_bench;
	logic        mclk_i = 1'h0, rst_i = 1'h1, hsel_i = 1'h0, hwrite_i = 1'h0;
	logic [7:0]  haddr_i = 8'h0;
	logic [1:0]  htrans_i = 2'h0;
	logic [2:0]  hsize_i = 3'h2;
	logic [31:0] hwdata_i = 32'h0, hrdata_o, r;
	logic [3:0]  rx_fifo_count_i = 4'h0, lvl = 4'hf;
	logic        core_txd_i = 1'h1, core_tx_busy_i = 1'h0, core_irq_i = 1'h0;
	logic        core_tx_pending_i = 1'h0;
	logic [3:0]  tl [4] = '{4'h1, 4'h2, 4'h4, 4'h7};
	wire         hready_i, hreadyout_o, hresp_o, rts_n_o, dtr_n_o, txd_o, core_rxd_o, irq_o;
	wire         core_rx_enable_o, tx_start_allow_o, modem_chg_o, rxd_i, cts_n_i;
	wire         dsr_n_i, ri_n_i, dcd_n_i;
	int          miscompares = 0, n_tests = 0;
	assign hready_i = hreadyout_o;
	umc_modem_control DUT (.*);
	umc_remote_model u_rem (.txd_o(txd_o), .lvl_i(lvl), .rxd_i(rxd_i), .cts_n_i(cts_n_i),
		.pins_o({dcd_n_i, ri_n_i, dsr_n_i}));
	always #50 mclk_i = ~mclk_i;
	// ----
	// Bus and check tasks
	// ----
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel_i <= 1'h1;
		htrans_i <= 2'h2;
		hwrite_i <= w;
		haddr_i <= a;
		do @(posedge mclk_i); while (hready_i !== 1'h1);
		hsel_i <= 1'h0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge mclk_i); while (hready_i !== 1'h1);
		r = hrdata_o;
	endtask
	task w;
		repeat (6) @(posedge mclk_i);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'h1, a, d);
		w;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		#1ms;
		miscompares++;
		give_verdict;
	end
	// ----
	// Sequence
	// ----
	initial
	begin
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'h0;
		chk("pins", {rts_n_o, dtr_n_o}, 2'h3);
		ahb(1'h0, `UMC_ADDR_MLC, 32'h0);
		chk("mlc", r, 32'h0);
		ahb(1'h0, 8'h1c, 32'h0);
		chk("gap", r, 32'h0);
		chk("resp", {hreadyout_o, hresp_o}, 2'h2);
		wr(`UMC_ADDR_MLC, 32'h03);
		chk("pins", {rts_n_o, dtr_n_o}, 2'h0);
		ahb(1'h1, `UMC_ADDR_MLC, 32'h17);
		ahb(1'h0, `UMC_ADDR_MLC, 32'h0);
		chk("mlc", r, 32'h17);
		core_txd_i <= 1'h0;
		w;
		chk("loop", {txd_o, rts_n_o, dtr_n_o, core_rxd_o}, 4'he);
		ahb(1'h0, `UMC_ADDR_STAT, 32'h0);
		chk("lpst", r[3:0], 4'h7);
		core_txd_i <= 1'h1;
		wr(`UMC_ADDR_MLC, 32'h08);
		wr(`UMC_ADDR_IRQ_EN, 32'h02);
		lvl <= 4'hd;
		w;
		chk("irq", irq_o, 1'h1);
		wr(`UMC_ADDR_IRQ_EN, 32'h0);
		chk("mask", irq_o, 1'h0);
		wr(`UMC_ADDR_IRQ_CLR, 32'h1f);
		ahb(1'h0, `UMC_ADDR_IRQ_ST, 32'h0);
		chk("ist", r, 32'h0);
		core_irq_i <= 1'h1;
		w;
		chk("irq", irq_o, 1'h1);
		wr(`UMC_ADDR_MLC, 32'h20);
		chk("gate", irq_o, 1'h0);
		lvl <= 4'hc;
		w;
		chk("go", tx_start_allow_o, 1'h1);
		lvl <= 4'hd;
		w;
		chk("stop", tx_start_allow_o, 1'h0);
		ahb(1'h0, `UMC_ADDR_IRQ_ST, 32'h0);
		chk("ctsev", r[0], 1'h0);
		wr(`UMC_ADDR_MLC, 32'h22);
		for (int c = 0; c < 4; c++)
		begin
			wr(`UMC_ADDR_TRIG, 32'(c));
			rx_fifo_count_i <= tl[c] - 4'h1;
			w;
			chk("rts", rts_n_o, 1'h0);
			rx_fifo_count_i <= tl[c];
			w;
			chk("rts", rts_n_o, 1'h1);
			rx_fifo_count_i <= tl[c] - 4'h1;
			w;
			chk("rts", rts_n_o, 32'(c != 0));
			rx_fifo_count_i <= 4'h0;
			w;
			chk("rts", rts_n_o, 1'h0);
		end
		wr(`UMC_ADDR_MLC, 32'hc0);
		core_txd_i <= 1'h0;
		core_tx_busy_i <= 1'h1;
		w;
		chk("half", {core_rx_enable_o, core_rxd_o, dtr_n_o}, 3'h2);
		core_tx_busy_i <= 1'h0;
		w;
		chk("half", {core_rx_enable_o, core_rxd_o, dtr_n_o}, 3'h5);
		give_verdict;
	end
endmodule // umc_modem_control_bench
